// file: hdl/oss_pkg.sv
// Constants, types and sub-entry map of the output sync supervision block.
package oss_pkg;

    // Clock rate and the nanosecond step that one clock cycle represents.
    localparam int CLK_FREQ_MHZ = 250;
    localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
    localparam logic [31:0] CLK_NS_STEP = 32'(CLK_PERIOD_NS);

    // Sub-entry indices of the output synchronization parameter object.
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_MODE = 8'h01;
    localparam logic [7:0] SUB_CYCLE = 8'h02;
    localparam logic [7:0] SUB_SHIFT = 8'h03;
    localparam logic [7:0] SUB_SUPP = 8'h04;
    localparam logic [7:0] SUB_MINCYC = 8'h05;
    localparam logic [7:0] SUB_CALC = 8'h06;
    localparam logic [7:0] SUB_MINDLY = 8'h07;
    localparam logic [7:0] SUB_MEAS = 8'h08;
    localparam logic [7:0] SUB_MAXDLY = 8'h09;
    localparam logic [7:0] SUB_MISS = 8'h0b;
    localparam logic [7:0] SUB_OVR = 8'h0c;
    localparam logic [7:0] SUB_SHORT = 8'h0d;
    localparam logic [7:0] SUB_LATE = 8'h20;

    // Reset values and saturation limits.
    localparam logic [7:0] ENTRY_COUNT_RST = 8'h20;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] SUPP_RST = 16'h0001;
    localparam logic [15:0] MEAS_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [31:0] TIME_RST = 32'h0000_0000;
    localparam logic [31:0] NS_MAX = 32'hffff_ffff;
    localparam logic LATE_RST = 1'b0;

    // Measurement control values.
    localparam logic [15:0] MEAS_STOP = 16'h0000;
    localparam logic [15:0] MEAS_START = 16'h0001;

    // Supported-modes word layout.
    localparam int SUPP_FREE_BIT = 0;
    localparam int SUPP_SM2_BIT = 1;
    localparam int SUPP_DC_LO = 2;
    localparam int SUPP_SHIFT_LO = 4;
    localparam int SUPP_DYN_BIT = 14;
    localparam logic [1:0] SUPP_DC_CODE = 2'h1;
    localparam logic [1:0] SUPP_SHIFT_CODE = 2'h2;

    // Synchronization modes in their encoding order 0..3.
    typedef enum logic [1:0] {
        MODE_FREE_RUN,
        MODE_SM2,
        MODE_DC_SYNC0,
        MODE_DC_SYNC1
    } oss_mode_t;

    // Number of input-side timing values whose maxima are also kept.
    localparam int IN_TIMES = 3;

    // Object access request and answer.
    typedef struct packed {
        logic wr;
        logic [7:0] sub;
        logic [31:0] wdata;
    } oss_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } oss_rsp_t;

endpackage

// file: hdl/oss_sat_cnt16.sv
// Saturating 16-bit event counter.
`timescale 1ns/1ps
`default_nettype none
module oss_sat_cnt16
    import oss_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Event and count.
    input wire logic inc_i,
    output logic [15:0] cnt_o
);

    logic [15:0] cnt_q;

    // Holding at full scale keeps a huge fault count from reading as a small one.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= CNT_RST; // RULE17
        end else if (inc_i && cnt_q != CNT_MAX) begin
            cnt_q <= cnt_q + 16'h0001; // RULE17
        end
    end

    assign cnt_o = cnt_q;

endmodule // oss_sat_cnt16
`default_nettype wire

// file: hdl/oss_elapsed_ns.sv
// Saturating nanosecond stopwatch restarted by an event pulse.
`timescale 1ns/1ps
`default_nettype none
module oss_elapsed_ns
    import oss_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Restart and elapsed time.
    input wire logic start_i,
    output logic [31:0] ns_o
);

    logic [31:0] ns_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ns_q <= NS_MAX;
        end else if (start_i) begin
            ns_q <= TIME_RST;
        end else if (ns_q <= NS_MAX - CLK_NS_STEP) begin
            ns_q <= ns_q + CLK_NS_STEP;
        end else begin
            ns_q <= NS_MAX;
        end
    end

    assign ns_o = ns_q;

endmodule // oss_elapsed_ns
`default_nettype wire

// file: hdl/oss_top.sv
// Output sync manager parameter object with timing supervision.
//
// How it works
// RULE1: mode 0 free, 1 SM2, 2 SYNC0, 3 SYNC1.
// RULE2: cycle entry sets timer, master or DC period.
// RULE3: DC only: report SYNC0 to outputs delay.
// RULE4: supported-modes word bits; default 0x0001.
// RULE5: report smallest sustainable cycle period.
// RULE6: DC only: report minimum SYNC0-SYNC1 spacing.
// RULE7: write 1 starts, 0 stops measurement.
// RULE8: measurement keeps largest observed timing values.
// RULE9: new measurement clears previous maxima first.
// RULE10: DC only: report SYNC1 to outputs delay.
// RULE11: DC: count missed SM events in OPERATIONAL.
// RULE12: OPERATIONAL: count late-finishing or early cycles.
// RULE13: DC: count too-short SYNC0 to SYNC1 gaps.
// RULE14: DC: flag outputs applied too late.
// RULE15: entry count reads back 0x20.
// RULE16: minimum delay entry read-only, zero.
// RULE17: counters saturate and reset to zero.
// RULE18: late flag re-evaluated every output cycle.
`timescale 1ns/1ps
`default_nettype none
module oss_top
    import oss_pkg::*;
#(
    parameter logic [15:0] SUPPORTED_MODES = SUPP_RST
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Object access port.
    input wire logic acc_req_i,
    input wire oss_req_t acc_i,
    output oss_rsp_t acc_o,
    // Synchronization events and device state.
    input wire logic sm2_event_i,
    input wire logic sync0_i,
    input wire logic sync1_i,
    input wire logic op_state_i,
    input wire logic outputs_driven_i,
    output logic apply_o,
    // Input-side timing values and their maxima.
    input wire logic in_time_valid_i,
    input wire logic [IN_TIMES-1:0][31:0] in_time_i,
    output logic [IN_TIMES-1:0][31:0] in_max_o
);

    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    oss_mode_t mode_q;
    logic [31:0] cycle_q;
    logic [15:0] meas_q;
    logic [31:0] shift_q;
    logic [31:0] mincyc_q;
    logic [31:0] calc_q;
    logic [31:0] maxdly_q;
    logic late_q;
    logic busy_q;
    logic sm2_seen_q;
    logic [31:0] tick_cnt_q;
    oss_rsp_t rsp_q;
    logic [IN_TIMES-1:0][31:0] in_max_q;

    logic wr_ok;
    logic wr_mode;
    logic wr_meas;
    logic meas_clear;
    logic measuring;
    logic dc_mode;
    logic local_tick;
    logic trig;
    logic [31:0] period_cycles;
    logic [31:0] t0_ns;
    logic [31:0] t1_ns;
    logic [31:0] tt_ns;
    logic miss_inc;
    logic ovr_inc;
    logic short_inc;
    logic [15:0] miss_cnt;
    logic [15:0] ovr_cnt;
    logic [15:0] short_cnt;
    logic mode_ok;
    logic [31:0] rdata;
    logic rd_hit;

    assign dc_mode = (mode_q == MODE_DC_SYNC0) || (mode_q == MODE_DC_SYNC1);
    assign measuring = (meas_q == MEAS_START) && SUPPORTED_MODES[SUPP_DYN_BIT]; // RULE7

    // A mode is accepted only when the supported-modes word advertises it.
    always_comb begin
        unique case (acc_i.wdata[1:0])
            2'h0: mode_ok = SUPPORTED_MODES[SUPP_FREE_BIT]; // RULE4
            2'h1: mode_ok = SUPPORTED_MODES[SUPP_SM2_BIT]; // RULE4
            2'h2: mode_ok = SUPPORTED_MODES[SUPP_DC_LO+:2] == SUPP_DC_CODE; // RULE4
            2'h3: mode_ok = SUPPORTED_MODES[SUPP_DC_LO+:2] == SUPP_DC_CODE
                && SUPPORTED_MODES[SUPP_SHIFT_LO+:2] == SUPP_SHIFT_CODE; // RULE4
        endcase
        if (acc_i.wdata[31:2] != 30'h0) begin
            mode_ok = 1'b0;
        end
    end

    always_comb begin
        wr_ok = 1'b0;
        if (acc_i.sub == SUB_MODE) begin
            wr_ok = mode_ok;
        end else if (acc_i.sub == SUB_CYCLE) begin
            wr_ok = 1'b1;
        end else if (acc_i.sub == SUB_MEAS) begin
            wr_ok = acc_i.wdata == {16'h0, MEAS_START} || acc_i.wdata == {16'h0, MEAS_STOP};
        end
    end

    assign wr_mode = acc_req_i && acc_i.wr && wr_ok && acc_i.sub == SUB_MODE;
    assign wr_meas = acc_req_i && acc_i.wr && wr_ok && acc_i.sub == SUB_MEAS;
    assign meas_clear = wr_meas && acc_i.wdata[15:0] == MEAS_START && meas_q != MEAS_START; // RULE9

    // Writable entries.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_FREE_RUN;
            cycle_q <= TIME_RST;
            meas_q <= MEAS_RST;
        end else begin
            if (wr_mode) begin
                mode_q <= oss_mode_t'(acc_i.wdata[1:0]); // RULE1
            end
            if (acc_req_i && acc_i.wr && acc_i.sub == SUB_CYCLE) begin
                cycle_q <= acc_i.wdata; // RULE2
            end
            if (wr_meas) begin
                meas_q <= acc_i.wdata[15:0]; // RULE7
            end
        end
    end

    // Local timer for free run; a zero period leaves it idle.
    assign period_cycles = cycle_q / CLK_NS_STEP;
    assign local_tick = period_cycles != TIME_RST && tick_cnt_q >= period_cycles - 32'h1;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= TIME_RST;
        end else if (mode_q != MODE_FREE_RUN || local_tick) begin
            tick_cnt_q <= TIME_RST;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1; // RULE2
        end
    end

    // Cycle start chosen by the synchronization mode.
    always_comb begin
        unique case (mode_q)
            MODE_FREE_RUN: trig = local_tick; // RULE1
            MODE_SM2: trig = sm2_event_i; // RULE1
            MODE_DC_SYNC0: trig = sync0_i; // RULE1
            MODE_DC_SYNC1: trig = sync1_i; // RULE1
        endcase
    end

    assign apply_o = trig;

    oss_elapsed_ns u_since_sync0 (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .start_i(sync0_i),
        .ns_o(t0_ns)
    );

    oss_elapsed_ns u_since_sync1 (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .start_i(sync1_i),
        .ns_o(t1_ns)
    );

    oss_elapsed_ns u_since_trig (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .start_i(trig),
        .ns_o(tt_ns)
    );

    // A cycle is busy from its start until the output stage reports the outputs driven.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (trig) begin
            busy_q <= 1'b1;
        end else if (outputs_driven_i) begin
            busy_q <= 1'b0;
        end
    end

    // An SM event seen in the same cycle as SYNC0 counts toward the next SYNC0 period.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sm2_seen_q <= 1'b1;
        end else if (sm2_event_i) begin
            sm2_seen_q <= 1'b1;
        end else if (sync0_i) begin
            sm2_seen_q <= 1'b0;
        end
    end

    assign miss_inc = dc_mode && op_state_i && sync0_i && !sm2_seen_q; // RULE11
    assign ovr_inc = op_state_i && trig && (busy_q
        || (mode_q != MODE_FREE_RUN && cycle_q != TIME_RST && tt_ns < cycle_q)); // RULE12
    assign short_inc = dc_mode && sync1_i && t0_ns < calc_q; // RULE13

    oss_sat_cnt16 u_miss_cnt (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .inc_i(miss_inc),
        .cnt_o(miss_cnt)
    );

    oss_sat_cnt16 u_ovr_cnt (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .inc_i(ovr_inc),
        .cnt_o(ovr_cnt)
    );

    oss_sat_cnt16 u_short_cnt (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .inc_i(short_inc),
        .cnt_o(short_cnt)
    );

    // Late flag is decided again at every cycle end, and in DC modes a cycle that never finished is late.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            late_q <= LATE_RST;
        end else if (dc_mode && trig && busy_q) begin
            late_q <= 1'b1; // RULE14
        end else if (outputs_driven_i && busy_q) begin
            late_q <= dc_mode && cycle_q != TIME_RST && tt_ns > cycle_q; // RULE18
        end
    end

    // Maxima of the output-side timings while a measurement runs.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= TIME_RST;
            mincyc_q <= TIME_RST;
            calc_q <= TIME_RST;
            maxdly_q <= TIME_RST;
        end else if (meas_clear) begin
            shift_q <= TIME_RST; // RULE9
            mincyc_q <= TIME_RST;
            calc_q <= TIME_RST;
            maxdly_q <= TIME_RST;
        end else if (measuring && outputs_driven_i && busy_q) begin
            if (tt_ns > mincyc_q) begin
                mincyc_q <= tt_ns; // RULE5
            end
            if (dc_mode && t0_ns > shift_q) begin
                shift_q <= t0_ns; // RULE3
            end
            if (dc_mode && tt_ns > calc_q) begin
                calc_q <= tt_ns; // RULE6
            end
            if (mode_q == MODE_DC_SYNC1 && t1_ns > maxdly_q) begin
                maxdly_q <= t1_ns; // RULE10
            end
        end
    end

    // Input-side counterparts share the same start, clear and stop.
    for (genvar gi = 0; gi < IN_TIMES; gi++) begin : g_in_max
        always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
                in_max_q[gi] <= TIME_RST;
            end else if (meas_clear) begin
                in_max_q[gi] <= TIME_RST; // RULE9
            end else if (measuring && in_time_valid_i && in_time_i[gi] > in_max_q[gi]) begin
                in_max_q[gi] <= in_time_i[gi]; // RULE8
            end
        end
    end

    assign in_max_o = in_max_q;

    // Read multiplexer; unmapped sub-entries read zero and answer with an error.
    always_comb begin
        rdata = TIME_RST;
        rd_hit = 1'b1;
        unique case (acc_i.sub)
            SUB_COUNT: rdata = {24'h0, ENTRY_COUNT_RST}; // RULE15
            SUB_MODE: rdata = {30'h0, mode_q};
            SUB_CYCLE: rdata = cycle_q;
            SUB_SHIFT: rdata = shift_q;
            SUB_SUPP: rdata = {16'h0, SUPPORTED_MODES}; // RULE4
            SUB_MINCYC: rdata = mincyc_q;
            SUB_CALC: rdata = calc_q;
            SUB_MINDLY: rdata = TIME_RST; // RULE16
            SUB_MEAS: rdata = {16'h0, meas_q};
            SUB_MAXDLY: rdata = maxdly_q;
            SUB_MISS: rdata = {16'h0, miss_cnt};
            SUB_OVR: rdata = {16'h0, ovr_cnt};
            SUB_SHORT: rdata = {16'h0, short_cnt};
            SUB_LATE: rdata = {31'h0, late_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q.ack <= acc_req_i;
            rsp_q.err <= acc_req_i && (acc_i.wr ? !wr_ok : !rd_hit);
            rsp_q.rdata <= (acc_req_i && !acc_i.wr) ? rdata : TIME_RST;
        end
    end

    assign acc_o = rsp_q;

    sequence s_read_count;
        acc_req_i && !acc_i.wr && acc_i.sub == SUB_COUNT;
    endsequence

    sequence s_count_answer;
        acc_o.ack && !acc_o.err && acc_o.rdata == 32'h0000_0020;
    endsequence

    property p_entry_count;
        @(posedge mclk_i) disable iff (!rst_n) s_read_count |=> s_count_answer;
    endproperty
    a_entry_count: assert property (p_entry_count) else $error("entry count read wrong"); // RULE15

    property p_mode_sync0;
        @(posedge mclk_i) disable iff (!rst_n) mode_q == MODE_DC_SYNC0 |-> apply_o == sync0_i;
    endproperty
    a_mode_sync0: assert property (p_mode_sync0) else $error("SYNC0 mode start mismatch"); // RULE1

    property p_meas_start;
        @(posedge mclk_i) disable iff (!rst_n)
            acc_req_i && acc_i.wr && acc_i.sub == SUB_MEAS && acc_i.wdata == 32'h1
            |=> meas_q == MEAS_START && acc_o.ack && !acc_o.err;
    endproperty
    a_meas_start: assert property (p_meas_start) else $error("measurement start not stored"); // RULE7

    property p_clear_on_start;
        @(posedge mclk_i) disable iff (!rst_n) meas_clear |=> shift_q == 32'h0 && mincyc_q == 32'h0;
    endproperty
    a_clear_on_start: assert property (p_clear_on_start) else $error("maxima not cleared"); // RULE9

    property p_shift_max;
        @(posedge mclk_i) disable iff (!rst_n)
            !meas_clear && measuring && outputs_driven_i && busy_q && dc_mode && t0_ns > shift_q
            |=> shift_q == $past(t0_ns);
    endproperty
    a_shift_max: assert property (p_shift_max) else $error("shift maximum not captured"); // RULE8

    property p_miss_count;
        @(posedge mclk_i) disable iff (!rst_n)
            miss_inc && miss_cnt != 16'hffff |=> miss_cnt == $past(miss_cnt) + 16'h1;
    endproperty
    a_miss_count: assert property (p_miss_count) else $error("missed event not counted"); // RULE11

    property p_ovr_count;
        @(posedge mclk_i) disable iff (!rst_n)
            op_state_i && trig && busy_q && ovr_cnt != 16'hffff |=> ovr_cnt == $past(ovr_cnt) + 16'h1;
    endproperty
    a_ovr_count: assert property (p_ovr_count) else $error("overrun not counted"); // RULE12

    property p_short_count;
        @(posedge mclk_i) disable iff (!rst_n)
            !dc_mode |=> short_cnt == $past(short_cnt);
    endproperty
    a_short_count: assert property (p_short_count) else $error("short gap counted outside DC"); // RULE13

    property p_late_set;
        @(posedge mclk_i) disable iff (!rst_n) dc_mode && trig && busy_q |=> late_q;
    endproperty
    a_late_set: assert property (p_late_set) else $error("late cycle not flagged"); // RULE14

    property p_late_clear;
        @(posedge mclk_i) disable iff (!rst_n)
            !trig && outputs_driven_i && busy_q && (cycle_q == 32'h0 || tt_ns <= cycle_q) |=> !late_q;
    endproperty
    a_late_clear: assert property (p_late_clear) else $error("late flag not cleared"); // RULE18

    property p_sat;
        @(posedge mclk_i) disable iff (!rst_n) ovr_inc |=> ovr_cnt != 16'h0000;
    endproperty
    a_sat: assert property (p_sat) else $error("counter wrapped"); // RULE17

endmodule // oss_top
`default_nettype wire

// file: testbench/oss_master_model.sv
// Behavioural model of the master side that issues the synchronization events.
`timescale 1ns/1ps
`default_nettype none
module oss_master_model (
    // Clock.
    input wire logic mclk_i,
    // Event pulses.
    output logic sm2_o,
    output logic sync0_o,
    output logic sync1_o
);
    initial begin
        {sm2_o, sync0_o, sync1_o} = 3'h0;
    end

    // Pulses are dropped on the edge that takes them, so each one spans one edge only.
    always @(posedge mclk_i) begin
        {sm2_o, sync0_o, sync1_o} <= 3'h0;
    end

    // Mask order is sm2, sync0, sync1; several events may share one cycle.
    task automatic fire(input logic [2:0] m);
        @(negedge mclk_i);
        {sm2_o, sync0_o, sync1_o} = m;
    endtask
endmodule // oss_master_model
`default_nettype wire

// file: testbench/tb_oss_top.sv
// Self-checking testbench of the output sync supervision block.
`timescale 1ns/1ps
`default_nettype none
module tb_oss_top;
    import oss_pkg::*;
    localparam logic [15:0] SUPP = 16'h4027;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic acc_req;
    oss_req_t req;
    oss_rsp_t rsp;
    logic sm2, s0, s1, apply;
    logic op;
    logic od;
    logic iv;
    logic [IN_TIMES-1:0][31:0] it;
    logic [IN_TIMES-1:0][31:0] imax;
    logic [31:0] mdl [0:32];
    logic [31:0] mx [IN_TIMES];
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'hca966254;

    oss_top #(.SUPPORTED_MODES(SUPP)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .acc_req_i(acc_req),
        .acc_i(req), .acc_o(rsp), .sm2_event_i(sm2), .sync0_i(s0), .sync1_i(s1), .op_state_i(op),
        .outputs_driven_i(od), .apply_o(apply), .in_time_valid_i(iv), .in_time_i(it), .in_max_o(imax));
    oss_master_model mst (.mclk_i(mclk_i), .sm2_o(sm2), .sync0_o(s0), .sync1_o(s1));

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // One-cycle strobes fall on the edge that takes them; the cycle limit cuts a hang short.
    always @(posedge mclk_i) begin
        od <= 1'b0;
        iv <= 1'b0;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic nc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic rst();
        rst_n_i = 1'b0;
        op = 1'b0;
        acc_req = 1'b0;
        req = '0;
        od = 1'b0;
        iv = 1'b0;
        it = '0;
        nc(12);
        rst_n_i = 1'b1;
        nc(4);
        for (int s = 0; s <= 32; s++) mdl[s] = 32'h0;
        mdl[SUB_COUNT] = 32'h20;
        mdl[SUB_SUPP] = {16'h0, SUPP};
    endtask

    // The request is held across exactly one taking edge; the answer stands in the next cycle.
    task automatic acc(input logic wr, input logic [7:0] sub, input logic [31:0] wd);
        nc(1);
        acc_req = 1'b1;
        req = '{wr: wr, sub: sub, wdata: wd};
        nc(1);
        acc_req = 1'b0;
    endtask

    task automatic rd(input logic [7:0] sub, input logic e);
        acc(1'b0, sub, 32'h0);
        chk($sformatf("entry %h", sub), {rsp.ack, rsp.err, rsp.rdata}, {1'b1, e, e ? 32'h0 : mdl[sub]});
    endtask

    task automatic wr(input logic [7:0] sub, input logic [31:0] wd, input logic e);
        acc(1'b1, sub, wd);
        chk($sformatf("write %h", sub), {32'h0, rsp.ack, rsp.err}, {32'h0, 1'b1, e});
        if (!e) mdl[sub] = wd;
    endtask

    task automatic done_pulse();
        nc(1);
        od = 1'b1;
    endtask

    task automatic dc_cycle(input int k);
        mst.fire(3'b010);
        nc(k);
        done_pulse();
    endtask

    initial begin
        int n;
        rst();
        wr(SUB_SUPP, 32'h0, 1'b1);
        wr(SUB_MINDLY, 32'h5, 1'b1);
        wr(SUB_MODE, 32'h4, 1'b1);
        wr(SUB_MEAS, 32'h2, 1'b1);
        wr(SUB_CYCLE, 32'($random(seed)), 1'b0);
        for (int s = 0; s <= 32; s++)
            if ((s <= 13 && s != 10) || s == 32) rd(8'(s), 1'b0);
        rd(8'h0a, 1'b1);
        $display("test registers done");

        wr(SUB_CYCLE, 32'h0, 1'b0);
        for (int m = 1; m < 4; m++) begin
            wr(SUB_MODE, 32'(m), 1'b0);
            for (int e = 0; e < 3; e++) begin
                mst.fire(3'b100 >> e);
                #1 chk("apply", {33'h0, apply}, {33'h0, m == e + 1});
                done_pulse();
            end
        end
        wr(SUB_MODE, 32'h0, 1'b0);
        wr(SUB_CYCLE, 32'd40, 1'b0);
        n = 0;
        repeat (100) begin
            nc(1);
            n += apply;
        end
        chk("ticks", 34'(n), 34'd10);
        $display("test modes done");

        rst();
        wr(SUB_MODE, 32'h2, 1'b0);
        op = 1'b1;
        dc_cycle(0);
        mst.fire(3'b100);
        dc_cycle(0);
        mst.fire(3'b010);
        mst.fire(3'b010);
        mdl[SUB_MISS] = 32'h2;
        mdl[SUB_OVR] = 32'h1;
        mdl[SUB_LATE] = 32'h1;
        rd(SUB_MISS, 1'b0);
        rd(SUB_OVR, 1'b0);
        rd(SUB_LATE, 1'b0);
        done_pulse();
        mdl[SUB_LATE] = 32'h0;
        rd(SUB_LATE, 1'b0);
        op = 1'b0;
        mst.fire(3'b010);
        mst.fire(3'b010);
        rd(SUB_OVR, 1'b0);
        rd(SUB_MISS, 1'b0);
        done_pulse();
        $display("test counters done");

        wr(SUB_MEAS, 32'h1, 1'b0);
        rd(SUB_MEAS, 1'b0);
        dc_cycle(4);
        dc_cycle(9);
        mdl[SUB_SHIFT] = 32'd36;
        mdl[SUB_MINCYC] = 32'd36;
        mdl[SUB_CALC] = 32'd36;
        rd(SUB_SHIFT, 1'b0);
        rd(SUB_MINCYC, 1'b0);
        rd(SUB_CALC, 1'b0);
        for (int i = 0; i < IN_TIMES; i++) mx[i] = 32'h0;
        repeat (2) begin
            nc(1);
            for (int i = 0; i < IN_TIMES; i++) begin
                it[i] = $random(seed);
                if (it[i] > mx[i]) mx[i] = it[i];
            end
            iv = 1'b1;
        end
        nc(2);
        for (int i = 0; i < IN_TIMES; i++) chk("in_max", {2'h0, imax[i]}, {2'h0, mx[i]});
        mst.fire(3'b010);
        nc(1);
        mst.fire(3'b001);
        done_pulse();
        mdl[SUB_SHORT] = 32'h1;
        rd(SUB_SHORT, 1'b0);
        wr(SUB_MEAS, 32'h0, 1'b0);
        wr(SUB_MEAS, 32'h1, 1'b0);
        mdl[SUB_SHIFT] = 32'h0;
        mdl[SUB_MINCYC] = 32'h0;
        mdl[SUB_CALC] = 32'h0;
        rd(SUB_SHIFT, 1'b0);
        rd(SUB_MINCYC, 1'b0);
        rd(SUB_CALC, 1'b0);
        for (int i = 0; i < IN_TIMES; i++) chk("in_max", {2'h0, imax[i]}, 34'h0);
        // In SYNC1 mode the cycle starts on SYNC1, so the SYNC1-to-driven time is four cycles here.
        wr(SUB_MODE, 32'h3, 1'b0);
        mst.fire(3'b001);
        nc(4);
        done_pulse();
        mdl[SUB_MAXDLY] = 32'd16;
        mdl[SUB_MINCYC] = 32'd16;
        rd(SUB_MAXDLY, 1'b0);
        rd(SUB_MINCYC, 1'b0);
        $display("test measurement done");
        report_and_stop();
    end
endmodule // tb_oss_top
`default_nettype wire
